// File: port_classifier.sv
/*
 * combinational priority and egress tag decision for one port.
 * assumes frame facts are stable in the cycle they are presented.
 */
`timescale 1ns/1ps
module port_classifier
    import port_priority_tag_pkg::*;
(
    port_classify_if.classifier cls
);
    // =====================================================
    // decision
    logic [1:0] pcp_prio;
    logic use_dot1p;
    logic use_dscp;

    always_comb begin
        pcp_prio = cls.prio_map[{cls.tag_pcp, 1'b0} +: 2]; // R12
        use_dot1p = cls.ctrl[dot1p_bit] && cls.is_tagged; // R4
        use_dscp = cls.ctrl[diffserv_bit] && cls.is_ipv4 && cls.dscp_hit; // R3
        if (use_dot1p || use_dscp) begin
            cls.queue = (use_dot1p ? pcp_prio : 2'h0) | (use_dscp ? cls.dscp_prio : 2'h0); // R6
        end else begin
            cls.queue = cls.ctrl[default_prio_hi:default_prio_lo]; // R5
        end
        cls.storm_protect = cls.ctrl[storm_bit] && cls.is_broadcast; // R2
        cls.insert_tag = cls.ctrl[tag_insert_bit] && !cls.is_tagged && cls.tag_setup_done; // R7 R8
        cls.remove_tag = cls.ctrl[tag_remove_bit] && cls.is_tagged; // R9
        cls.four_queues = cls.ctrl[split_bit] && !cls.split_two; // R10 R11
        cls.single_queue = !cls.four_queues;
    end
endmodule : port_classifier

// File: port_classify_if.sv
/*
 * carries a port's control byte, map and frame facts to the classifier.
 * assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
interface port_classify_if;
    logic [7:0] ctrl;
    logic [15:0] prio_map;
    logic tag_setup_done;
    logic split_two;
    logic [2:0] tag_pcp;
    logic is_tagged;
    logic is_ipv4;
    logic [1:0] dscp_prio;
    logic dscp_hit;
    logic is_broadcast;
    logic storm_protect;
    logic [1:0] queue;
    logic insert_tag;
    logic remove_tag;
    logic four_queues;
    logic single_queue;
    modport bank (output ctrl, prio_map, tag_setup_done, split_two, tag_pcp, is_tagged,
        is_ipv4, dscp_prio, dscp_hit, is_broadcast,
        input storm_protect, queue, insert_tag, remove_tag, four_queues, single_queue);
    modport classifier (input ctrl, prio_map, tag_setup_done, split_two, tag_pcp,
        is_tagged, is_ipv4, dscp_prio, dscp_hit, is_broadcast,
        output storm_protect, queue, insert_tag, remove_tag, four_queues, single_queue);
endinterface : port_classify_if

// File: port_priority_tag_chk.sv
/* checks apb answers and registered port outputs of the priority and tag bank.
   sees only the top module's ports; attached by bind. */
`timescale 1ns/1ps
module port_priority_tag_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] is_broadcast,
    input wire logic [2:0] is_tagged,
    input wire logic [2:0] storm_protect,
    input wire logic [2:0] insert_tag,
    input wire logic [2:0] remove_tag,
    input wire logic [2:0] transmit_queue_four_way_split,
    input wire logic [2:0] transmit_queue_single
);
    // =====================================
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_pready_access: assert property (psel && penable |-> pready)
        else $error("no ready in access phase");
    chk_pready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error without ready or with data");
    chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_storm_cause: assert property ((storm_protect & ~$past(is_broadcast)) == 3'h0)
        else $error("storm protect without broadcast");
    chk_insert_untagged: assert property ((insert_tag & $past(is_tagged)) == 3'h0)
        else $error("tag inserted on tagged frame");
    chk_remove_tagged: assert property ((remove_tag & ~$past(is_tagged)) == 3'h0)
        else $error("tag removed from untagged frame");
    chk_queue_modes: assert property ($past(presetn) |->
        (transmit_queue_four_way_split ^ transmit_queue_single) == 3'h7)
        else $error("queue modes not exclusive");
endmodule : port_priority_tag_chk

bind port_priority_tag_control port_priority_tag_chk u_chk (.*);

// File: port_priority_tag_control.sv
/*
 * apb register bank for the three per-port priority and tag controls,
 * the 802.1p map, and registered per-port classification results.
 * assumes apb master on pclk, frame facts synchronous to pclk.
 */
// Operation
// (R1) three eight-bit port registers, reset zero
// (R2) bit 7 enables ingress broadcast storm protection
// (R3) bit 6 enables DiffServ classification for IPv4
// (R4) bit 5 enables 802.1p tag classification
// (R5) bits 4:3 give default queue
// (R6) enabled classifiers OR together, overriding default
// (R7) bit 2 inserts tag on untagged frames
// (R8) software programs tag setup bits first
// (R9) bit 1 strips tag from tagged frames
// (R10) bit 0 splits transmit queue four ways
// (R11) software never sets both split modes
// (R12) 802.1p value maps through programmable table
`timescale 1ns/1ps
module port_priority_tag_control
    import port_priority_tag_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] is_broadcast,
    input wire logic [2:0] is_tagged,
    input wire logic [2:0] is_ipv4,
    input wire logic [8:0] tag_pcp,
    input wire logic [5:0] dscp_prio,
    input wire logic [2:0] dscp_hit,
    output logic [2:0] storm_protect,
    output logic [5:0] queue,
    output logic [2:0] insert_tag,
    output logic [2:0] remove_tag,
    output logic [2:0] transmit_queue_four_way_split,
    output logic [2:0] transmit_queue_single
);
    // =====================================================
    // state
    regs_type r;
    regs_type next_r;
    port_out_type [num_ports-1:0] res;
    port_out_type [num_ports-1:0] res_q;
    port_out_type [num_ports-1:0] next_res_q;

    // =====================================================
    // per-port classifiers
    genvar g;
    generate
        for (g = 0; g < num_ports; g++) begin : gen_port
            port_classify_if pif ();
            assign pif.ctrl = r.port_ctrl[g];
            assign pif.prio_map = {r.map_high, r.map_low}; // R12
            assign pif.tag_setup_done = &r.tag_setup; // R8
            assign pif.split_two = r.split_two[g]; // R11
            assign pif.tag_pcp = tag_pcp[g*3 +: 3];
            assign pif.is_tagged = is_tagged[g];
            assign pif.is_ipv4 = is_ipv4[g];
            assign pif.dscp_prio = dscp_prio[g*2 +: 2];
            assign pif.dscp_hit = dscp_hit[g];
            assign pif.is_broadcast = is_broadcast[g];
            assign res[g].storm_protect = pif.storm_protect;
            assign res[g].queue = pif.queue;
            assign res[g].insert_tag = pif.insert_tag;
            assign res[g].remove_tag = pif.remove_tag;
            assign res[g].four_queues = pif.four_queues;
            assign res[g].single_queue = pif.single_queue;
            port_classifier u_cls (
                .cls(pif.classifier)
            );
            assign storm_protect[g] = res_q[g].storm_protect;
            assign queue[g*2 +: 2] = res_q[g].queue;
            assign insert_tag[g] = res_q[g].insert_tag;
            assign remove_tag[g] = res_q[g].remove_tag;
            assign transmit_queue_four_way_split[g] = res_q[g].four_queues;
            assign transmit_queue_single[g] = res_q[g].single_queue;
        end
    endgenerate

    // =====================================================
    // apb decode
    logic access;
    logic do_write;
    logic [31:0] rdata;
    logic hit;

    always_comb begin
        next_r = r;
        next_res_q = res;
        access = psel && !penable;
        do_write = 1'b0;
        rdata = 32'h0000_0000;
        hit = 1'b1;
        next_r.pready = 1'b0;
        if (psel && penable && r.pready) begin
            next_r.pready = 1'b0;
        end else if (access) begin
            next_r.pready = 1'b1;
        end
        if (paddr == port1_priority_tag_ctrl_offset) begin
            rdata = {24'h000000, r.port_ctrl[0]};
        end else if (paddr == port2_priority_tag_ctrl_offset) begin
            rdata = {24'h000000, r.port_ctrl[1]};
        end else if (paddr == port3_priority_tag_ctrl_offset) begin
            rdata = {24'h000000, r.port_ctrl[2]};
        end else if (paddr == prio_map_low_offset) begin
            rdata = {24'h000000, r.map_low};
        end else if (paddr == prio_map_high_offset) begin
            rdata = {24'h000000, r.map_high};
        end else if (paddr == global_tag_setup_offset) begin
            rdata = {26'h0000000, r.tag_setup};
        end else if (paddr == split_two_offset) begin
            rdata = {29'h00000000, r.split_two};
        end else begin
            hit = 1'b0;
        end
        next_r.pslverr = 1'b0;
        next_r.prdata = 32'h0000_0000;
        if (access) begin
            next_r.pslverr = !hit;
            next_r.prdata = (pwrite || !hit) ? 32'h0000_0000 : rdata;
        end
        // write lands at the access edge where pready is seen high
        do_write = psel && penable && r.pready && pwrite && hit;
        if (do_write) begin
            if (paddr == port1_priority_tag_ctrl_offset) begin
                next_r.port_ctrl[0] = pwdata[7:0]; // R1
            end else if (paddr == port2_priority_tag_ctrl_offset) begin
                next_r.port_ctrl[1] = pwdata[7:0]; // R1
            end else if (paddr == port3_priority_tag_ctrl_offset) begin
                next_r.port_ctrl[2] = pwdata[7:0]; // R1
            end else if (paddr == prio_map_low_offset) begin
                next_r.map_low = pwdata[7:0]; // R12
            end else if (paddr == prio_map_high_offset) begin
                next_r.map_high = pwdata[7:0]; // R12
            end else if (paddr == global_tag_setup_offset) begin
                next_r.tag_setup = pwdata[5:0];
            end else begin
                next_r.split_two = pwdata[2:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r.port_ctrl <= {num_ports{port_ctrl_reset}}; // R1
            r.map_low <= prio_map_low_reset;
            r.map_high <= prio_map_high_reset;
            r.tag_setup <= global_tag_setup_reset;
            r.split_two <= split_two_reset;
            r.prdata <= 32'h0000_0000;
            r.pready <= 1'b0;
            r.pslverr <= 1'b0;
            res_q <= '0;
        end else begin
            r <= next_r;
            res_q <= next_res_q;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
endmodule : port_priority_tag_control

// File: port_priority_tag_pkg.sv
/*
 * constants and types for the per-port priority and tag control bank.
 * assumes a single 10 MHz apb clock domain.
 */
package port_priority_tag_pkg;

    // =====================================================
    // register map
    localparam logic [11:0] port1_priority_tag_ctrl_offset = 12'h010;
    localparam logic [11:0] port2_priority_tag_ctrl_offset = 12'h020;
    localparam logic [11:0] port3_priority_tag_ctrl_offset = 12'h030;
    localparam logic [11:0] prio_map_low_offset = 12'h040;
    localparam logic [11:0] prio_map_high_offset = 12'h044;
    localparam logic [11:0] global_tag_setup_offset = 12'h048;
    localparam logic [11:0] split_two_offset = 12'h04c;

    // =====================================================
    // field positions
    localparam int storm_bit = 7;
    localparam int diffserv_bit = 6;
    localparam int dot1p_bit = 5;
    localparam int default_prio_hi = 4;
    localparam int default_prio_lo = 3;
    localparam int tag_insert_bit = 2;
    localparam int tag_remove_bit = 1;
    localparam int split_bit = 0;

    // =====================================================
    // reset values
    localparam logic [7:0] port_ctrl_reset = 8'h00;
    localparam logic [7:0] prio_map_low_reset = 8'h50;
    localparam logic [7:0] prio_map_high_reset = 8'hfa;
    localparam logic [5:0] global_tag_setup_reset = 6'h00;
    localparam logic [2:0] split_two_reset = 3'h0;
    localparam int num_ports = 3;

    typedef struct packed {
        logic [num_ports-1:0][7:0] port_ctrl;
        logic [7:0] map_low;
        logic [7:0] map_high;
        logic [5:0] tag_setup;
        logic [2:0] split_two;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } regs_type;

    typedef struct packed {
        logic storm_protect;
        logic [1:0] queue;
        logic insert_tag;
        logic remove_tag;
        logic four_queues;
        logic single_queue;
    } port_out_type;

endpackage : port_priority_tag_pkg

// File: test_port_priority_tag_control.sv
/* self-checking bench for the priority and tag bank: apb master and frame facts.
   assumes zero wait apb slave and outputs one cycle after the facts. */
`timescale 1ns/1ps
module test_port_priority_tag_control
    import port_priority_tag_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0] bc = 0, tg = 0, ip = 0, hit = 0, storm, ins, rem, four, single;
    logic [8:0] pcp = 0;
    logic [5:0] dp = 0, queue;
    logic err;
    int failures = 0, n_compared = 0;
    port_priority_tag_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .is_broadcast(bc),
        .is_tagged(tg), .is_ipv4(ip), .tag_pcp(pcp), .dscp_prio(dp), .dscp_hit(hit),
        .storm_protect(storm), .queue(queue), .insert_tag(ins), .remove_tag(rem),
        .transmit_queue_four_way_split(four), .transmit_queue_single(single));
    always #50 pclk = ~pclk;
    // =====================================
    // shared tasks
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task ports(input logic [31:0] d);
        apb(1, port1_priority_tag_ctrl_offset, d);
        apb(1, port2_priority_tag_ctrl_offset, d);
        apb(1, port3_priority_tag_ctrl_offset, d);
    endtask : ports
    task facts(input logic b, t, i, h, input logic [2:0] p, input logic [1:0] q);
        @(posedge pclk);
        {bc, tg, ip, hit, pcp, dp} <= {{3{b}}, {3{t}}, {3{i}}, {3{h}}, {3{p}}, {3{q}}};
        repeat (2) @(posedge pclk);
        #1;
    endtask : facts
    // =====================================
    // scenarios
    task t_regs;
        apb(0, port2_priority_tag_ctrl_offset, 0); check(rd, 32'h0);
        apb(0, prio_map_low_offset, 0); check(rd, 32'h50);
        apb(0, prio_map_high_offset, 0); check(rd, 32'hfa);
        apb(1, port1_priority_tag_ctrl_offset, 32'hffffff5a);
        apb(1, 12'h014, 32'hff);
        check(32'(err), 32'h1);
        apb(0, 12'h014, 0); check({31'(rd), err}, 32'h1);
        apb(0, port1_priority_tag_ctrl_offset, 0); check(rd, 32'h5a);
    endtask : t_regs
    task t_prio;
        ports(32'h18); facts(0, 1, 1, 1, 3, 2); check(32'(queue), 32'h3f);
        ports(32'h20); facts(0, 1, 0, 0, 3, 0); check(32'(queue), 32'h15);
        facts(0, 1, 0, 0, 7, 0); check(32'(queue), 32'h3f);
        ports(32'h40); facts(0, 0, 1, 1, 0, 2); check(32'(queue), 32'h2a);
        facts(0, 0, 1, 0, 0, 2); check(32'(queue), 32'h0);
        ports(32'h78); facts(0, 1, 1, 1, 3, 0); check(32'(queue), 32'h15);
        facts(0, 1, 1, 1, 1, 2); check(32'(queue), 32'h2a);
    endtask : t_prio
    task t_tag;
        ports(32'h86); facts(1, 0, 0, 0, 0, 0); check({storm, ins}, 32'h38);
        apb(1, global_tag_setup_offset, 32'h3f);
        facts(1, 0, 0, 0, 0, 0); check({ins, rem}, 32'h38);
        facts(1, 1, 0, 0, 0, 0); check({ins, rem}, 32'h07);
        ports(32'h00); facts(1, 1, 0, 0, 0, 0); check({storm, rem}, 32'h0);
    endtask : t_tag
    task t_split;
        ports(32'h01); facts(0, 0, 0, 0, 0, 0); check({four, single}, 32'h38);
        ports(32'h00);
        apb(1, split_two_offset, 32'h7);
        facts(0, 0, 0, 0, 0, 0); check({four, single}, 32'h07);
    endtask : t_split
    // =====================================
    // run control
    task report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1;
        t_regs;
        t_prio;
        t_tag;
        t_split;
        report_and_stop;
    end
    initial begin
        #400000;
        failures++;
        report_and_stop;
    end
endmodule : test_port_priority_tag_control
